// >>> design/rlts_top.sv
// Overview of operation
// - zero-going change is accepted only after switch-off delay; default three minutes.
// - during a running switch-off delay, cyclic telegrams still carry one.
// - inhibit setting suppresses cyclic and event telegrams while condition holds.
// - send-on-change off: no change telegram; cyclic repeat still runs if set.
// - send-on-change on: telegram on every accepted transition, both directions.
// - send-on-change off and cycle zero: never transmit.
// - cycle setting 0..120, period setting times ten seconds, zero disables.
// - polarity picks one or zero when raining; default zero when raining.
// - missing sensor supply makes rain count as present always.
// - one-going change is accepted only after switch-on delay.
// - delay choices go on through 1,3,5,10,15,30 and 60 minutes.
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module rlts_top #(
	parameter int unsigned SEC_CYCLES = rlts_pkg::SEC_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// sensor inputs
	input wire logic rain_i,
	input wire logic supply_ok_i,
	// telegram output
	output logic tx_req_o,
	output logic tx_val_o,
	output logic lim_val_o,
	// interrupt
	output logic irq_o
);
	typedef enum logic [1:0] {
		RLTS_IDLE = 2'b00,
		RLTS_WAIT = 2'b01
	} rlts_dly_t;

	logic sec_tick;
	rlts_sec_tick #(.SEC_CYCLES(SEC_CYCLES)) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_o(sec_tick)
	);

	// configuration
	logic pol_ff;
	logic soc_ff;
	logic inh_ff;
	logic inh_val_ff;
	logic [3:0] on_dly_ff;
	logic [3:0] off_dly_ff;
	logic [6:0] cycle_ff;
	logic [rlts_pkg::IRQ_W-1:0] irq_stat_ff;
	logic [rlts_pkg::IRQ_W-1:0] irq_en_ff;
	logic [15:0] tx_cnt_ff;
	// state
	rlts_dly_t dst_ff;
	logic [11:0] dly_cnt_ff;
	logic [10:0] cyc_cnt_ff;
	logic supply_ff;

	// bus decode
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// a write lands at the edge where the master sees ack high
	wire wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	wire wr_ctrl = wb_wr & (wb_adr_i == rlts_pkg::REG_CTRL);
	wire wr_cycle = wb_wr & (wb_adr_i == rlts_pkg::REG_CYCLE);
	wire wr_en = wb_wr & (wb_adr_i == rlts_pkg::REG_IRQ_EN);
	wire wr_clr = wb_wr & (wb_adr_i == rlts_pkg::REG_IRQ_CLR);

	// rain and target value
	wire rain = rain_i | ~supply_ok_i;
	wire target = pol_ff ? rain : ~rain;
	wire differs = (target != lim_val_o);
	wire [3:0] dly_code = target ? on_dly_ff : off_dly_ff;
	wire [11:0] dly_sec = rlts_pkg::rlts_dly_sec(dly_code);
	wire zero_dly = (dly_sec == 12'h000);
	wire dly_done = (dst_ff == RLTS_WAIT) & sec_tick & (dly_cnt_ff <= 12'h001);
	wire start_wait = (dst_ff == RLTS_IDLE) & differs;
	wire accept = differs & ((start_wait & zero_dly) | dly_done);
	wire nxt_lim = accept ? target : lim_val_o;

	// cyclic repeat
	wire [10:0] cyc_period = 11'(cycle_ff * 11'(rlts_pkg::CYC_STEP_S));
	wire cyc_on = (cycle_ff != 7'h00);
	wire cyc_fire = cyc_on & sec_tick & (cyc_cnt_ff <= 11'h001);
	wire inhibit = inh_ff & (lim_val_o == inh_val_ff);
	wire chg_fire = soc_ff & accept;
	wire send = (cyc_fire | chg_fire) & ~inhibit;
	wire [rlts_pkg::IRQ_W-1:0] irq_set = {supply_ff & ~supply_ok_i, accept, send};

	wire [31:0] ctrl_rd = {16'h0, off_dly_ff, on_dly_ff, 4'h0, inh_val_ff, inh_ff, soc_ff, pol_ff};
	wire [31:0] state_rd = {24'h0, 2'h0, dst_ff, 1'b0, supply_ok_i, rain, lim_val_o};
	wire [31:0] nxt_rd =
		(wb_adr_i == rlts_pkg::REG_CTRL) ? ctrl_rd :
		(wb_adr_i == rlts_pkg::REG_CYCLE) ? {25'h0, cycle_ff} :
		(wb_adr_i == rlts_pkg::REG_STATE) ? state_rd :
		(wb_adr_i == rlts_pkg::REG_IRQ_STAT) ? {29'h0, irq_stat_ff} :
		(wb_adr_i == rlts_pkg::REG_IRQ_EN) ? {29'h0, irq_en_ff} :
		(wb_adr_i == rlts_pkg::REG_TX_CNT) ? {16'h0, tx_cnt_ff} : 32'h0;
	wire [6:0] wr_cyc = (wb_dat_i[6:0] > rlts_pkg::CYC_MAX) ? rlts_pkg::CYC_MAX : wb_dat_i[6:0];

	// bus slave
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? nxt_rd : 32'h0;
		end
	end

	// configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pol_ff <= rlts_pkg::CTRL_POL_RST;
			soc_ff <= 1'b0;
			inh_ff <= 1'b0;
			inh_val_ff <= 1'b0;
			on_dly_ff <= rlts_pkg::DLY_ON_RST;
			off_dly_ff <= rlts_pkg::DLY_OFF_RST;
			cycle_ff <= rlts_pkg::CYCLE_RST;
			irq_en_ff <= '0;
		end else begin
			if (wr_ctrl & wb_sel_i[0]) begin
				pol_ff <= wb_dat_i[rlts_pkg::CTRL_POL_BIT];
				soc_ff <= wb_dat_i[rlts_pkg::CTRL_SOC_BIT];
				inh_ff <= wb_dat_i[rlts_pkg::CTRL_INH_BIT];
				inh_val_ff <= wb_dat_i[rlts_pkg::CTRL_INHVAL_BIT];
			end
			if (wr_ctrl & wb_sel_i[1]) begin
				on_dly_ff <= wb_dat_i[rlts_pkg::CTRL_ON_LSB +: rlts_pkg::DLY_W];
				off_dly_ff <= wb_dat_i[rlts_pkg::CTRL_OFF_LSB +: rlts_pkg::DLY_W];
			end
			if (wr_cycle & wb_sel_i[0])
				cycle_ff <= wr_cyc;
			if (wr_en & wb_sel_i[0])
				irq_en_ff <= wb_dat_i[rlts_pkg::IRQ_W-1:0];
		end
	end

	// delay timer: cancels when target matches again
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dst_ff <= RLTS_IDLE;
			dly_cnt_ff <= 12'h000;
			lim_val_o <= 1'b0;
		end else begin
			lim_val_o <= nxt_lim;
			unique case (dst_ff)
				RLTS_IDLE: begin
					if (start_wait & ~zero_dly) begin
						dst_ff <= RLTS_WAIT;
						dly_cnt_ff <= dly_sec;
					end
				end
				RLTS_WAIT: begin
					if (~differs | dly_done)
						dst_ff <= RLTS_IDLE;
					else if (sec_tick)
						dly_cnt_ff <= dly_cnt_ff - 12'h001;
				end
				default: dst_ff <= RLTS_IDLE;
			endcase
		end
	end

	// sticky status bits, set wins over clear
	for (genvar b = 0; b < rlts_pkg::IRQ_W; b++) begin : g_irq
		wire clr_bit = wr_clr & wb_sel_i[0] & wb_dat_i[b];
		always_ff @(posedge clk_i) begin
			if (rst_i)
				irq_stat_ff[b] <= 1'b0;
			else
				irq_stat_ff[b] <= irq_set[b] | (irq_stat_ff[b] & ~clr_bit);
		end
	end

	// cyclic counter, telegram output, irq
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cyc_cnt_ff <= 11'h000;
			tx_req_o <= 1'b0;
			tx_val_o <= 1'b0;
			irq_o <= 1'b0;
			tx_cnt_ff <= 16'h0;
			supply_ff <= 1'b1;
		end else begin
			supply_ff <= supply_ok_i;
			if (~cyc_on | wr_cycle)
				cyc_cnt_ff <= cyc_period;
			else if (cyc_fire)
				cyc_cnt_ff <= cyc_period;
			else if (sec_tick)
				cyc_cnt_ff <= cyc_cnt_ff - 11'h001;
			tx_req_o <= send;
			tx_val_o <= send ? nxt_lim : tx_val_o;
			if (send)
				tx_cnt_ff <= tx_cnt_ff + 16'h1;
			irq_o <= |(irq_stat_ff & irq_en_ff);
		end
	end
endmodule : rlts_top
`default_nettype wire

// >>> include/rlts_pkg.sv
package rlts_pkg;
	// clock and timebase
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned SEC_CYCLES = CLK_HZ;
	localparam int unsigned CYC_STEP_S = 10;
	localparam logic [6:0] CYC_MAX = 7'h78;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CYCLE = 8'h04;
	localparam logic [7:0] REG_STATE = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
	localparam logic [7:0] REG_IRQ_EN = 8'h10;
	localparam logic [7:0] REG_IRQ_CLR = 8'h14;
	localparam logic [7:0] REG_TX_CNT = 8'h18;
	// ctrl fields
	localparam int unsigned CTRL_POL_BIT = 0;
	localparam int unsigned CTRL_SOC_BIT = 1;
	localparam int unsigned CTRL_INH_BIT = 2;
	localparam int unsigned CTRL_INHVAL_BIT = 3;
	localparam int unsigned CTRL_ON_LSB = 8;
	localparam int unsigned CTRL_OFF_LSB = 12;
	localparam int unsigned DLY_W = 4;
	// reset values: off when raining, no on delay, 3 min off delay
	localparam logic CTRL_POL_RST = 1'b0;
	localparam logic [3:0] DLY_ON_RST = 4'h0;
	localparam logic [3:0] DLY_OFF_RST = 4'h8;
	localparam logic [6:0] CYCLE_RST = 7'h00;
	// irq bits
	localparam int unsigned IRQ_W = 3;
	localparam int unsigned IRQ_TX = 0;
	localparam int unsigned IRQ_CHG = 1;
	localparam int unsigned IRQ_SUPPLY = 2;
	// delay code to seconds: none,1,3,5,10,15,30s,1,3,5,10,15,30,60min
	function automatic logic [11:0] rlts_dly_sec(input logic [3:0] code);
		unique case (code)
			4'h0: rlts_dly_sec = 12'h000;
			4'h1: rlts_dly_sec = 12'h001;
			4'h2: rlts_dly_sec = 12'h003;
			4'h3: rlts_dly_sec = 12'h005;
			4'h4: rlts_dly_sec = 12'h00A;
			4'h5: rlts_dly_sec = 12'h00F;
			4'h6: rlts_dly_sec = 12'h01E;
			4'h7: rlts_dly_sec = 12'h03C;
			4'h8: rlts_dly_sec = 12'h0B4;
			4'h9: rlts_dly_sec = 12'h12C;
			4'hA: rlts_dly_sec = 12'h258;
			4'hB: rlts_dly_sec = 12'h384;
			4'hC: rlts_dly_sec = 12'h708;
			4'hD: rlts_dly_sec = 12'hE10;
			default: rlts_dly_sec = 12'hE10;
		endcase
	endfunction : rlts_dly_sec
endpackage : rlts_pkg

// >>> design/rlts_sec_tick.sv
`timescale 1ns/1ns
`default_nettype none
// one-cycle pulse once per second
module rlts_sec_tick #(
	parameter int unsigned SEC_CYCLES = rlts_pkg::SEC_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// tick
	output logic tick_o
);
	logic [31:0] cnt_ff;
	wire last = (cnt_ff == 32'(SEC_CYCLES - 1));
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff <= 32'h0;
			tick_o <= 1'b0;
		end else begin
			cnt_ff <= last ? 32'h0 : cnt_ff + 32'h1;
			tick_o <= last;
		end
	end
endmodule : rlts_sec_tick
`default_nettype wire

// >>> bench/rlts_bus_rx.sv
`timescale 1ns/1ns
`default_nettype none
// telegram receiver: counts telegrams, keeps the last value
module rlts_bus_rx (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// telegram
	input wire logic req_i,
	input wire logic val_i,
	output logic [15:0] cnt_o,
	output logic last_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_o <= 16'h0000;
			last_o <= 1'b0;
		end else if (req_i) begin
			cnt_o <= cnt_o + 16'h0001;
			last_o <= val_i;
		end
	end
endmodule : rlts_bus_rx
`default_nettype wire

// >>> bench/rlts_top_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rlts_top_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic tx_req_o,
	input wire logic tx_val_o,
	input wire logic lim_val_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic soc_ff, inh_ff, cz_ff, en_ff;
	wire wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
	// mirror of the transmit settings and the interrupt enable, taken at the write's ack edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			soc_ff <= 1'b0;
			inh_ff <= 1'b0;
			cz_ff <= 1'b1;
			en_ff <= 1'b0;
		end else if (wr_ack) begin
			if (wb_adr_i == rlts_pkg::REG_CTRL) soc_ff <= wb_dat_i[1];
			if (wb_adr_i == rlts_pkg::REG_CTRL) inh_ff <= wb_dat_i[2];
			if (wb_adr_i == rlts_pkg::REG_CYCLE) cz_ff <= (wb_dat_i[6:0] == 7'h00);
			if (wb_adr_i == rlts_pkg::REG_IRQ_EN) en_ff <= |wb_dat_i[2:0];
		end
	end
	a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	a_tx_val_stable: assert property (!tx_req_o |-> $stable(tx_val_o))
		else $error("telegram value moved without telegram");
	a_tx_carries_lim: assert property (tx_req_o |-> tx_val_o == lim_val_o)
		else $error("telegram value differs from limiting value");
	a_silent_no_send: assert property (!soc_ff && cz_ff |-> !tx_req_o)
		else $error("telegram while sending is off");
	a_change_sends_tx: assert property (soc_ff && !inh_ff && $changed(lim_val_o) |-> tx_req_o)
		else $error("no telegram on accepted change");
	a_irq_masked_low: assert property (!en_ff |=> !irq_o)
		else $error("interrupt while all masked");
endmodule : rlts_top_checker
bind rlts_top rlts_top_checker i_rlts_top_checker (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.tx_req_o(tx_req_o), .tx_val_o(tx_val_o), .lim_val_o(lim_val_o), .irq_o(irq_o));
`default_nettype wire

// >>> bench/test_rlts_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_rlts_top;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, rain = 0, sup = 1;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, dout, rv;
	logic ack, txr, txv, lim, irq, last;
	logic [15:0] cnt, n;
	int errors = 0, n_compared = 0, t;
	rlts_top #(.SEC_CYCLES(10)) i_rlts_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
		.wb_dat_o(dout), .wb_ack_o(ack), .rain_i(rain), .supply_ok_i(sup), .tx_req_o(txr),
		.tx_val_o(txv), .lim_val_o(lim), .irq_o(irq));
	rlts_bus_rx i_rlts_bus_rx (.clk_i(clk_i), .rst_i(rst_i), .req_i(txr), .val_i(txv),
		.cnt_o(cnt), .last_o(last));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		rv = dout;
		{cyc, stb, we} <= 3'b000;
	endtask : bus
	task automatic wl(input logic v, input int m);
		for (int i = 0; i < m && lim !== v; i++) @(posedge clk_i);
		chk(lim, v);
	endtask : wl
	task automatic wt();
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (txr !== 1'b1 && t < 3000);
		chk(txr, 1'b1);
	endtask : wt
	task automatic end_sim();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim
	task automatic t_regs();
		bus(0, rlts_pkg::REG_CTRL, 0);
		chk(rv, 32'h8000);
		bus(0, 8'hFC, 0);
		chk(rv, 32'h0);
		bus(1, rlts_pkg::REG_CYCLE, 32'hFF);
		bus(0, rlts_pkg::REG_CYCLE, 0);
		chk(rv, 32'h78);
		bus(1, rlts_pkg::REG_CYCLE, 0);
	endtask : t_regs
	task automatic t_pol();
		bus(1, rlts_pkg::REG_CTRL, 32'h2);
		wl(1, 20);
		n = cnt;
		rain <= 1;
		wl(0, 20);
		repeat (2) @(posedge clk_i);
		chk({cnt, 15'h0, last}, {n + 16'h1, 16'h0});
		bus(1, rlts_pkg::REG_CTRL, 32'h3);
		wl(1, 20);
		rain <= 0;
		wl(0, 20);
		sup <= 0;
		wl(1, 20);
		sup <= 1;
		wl(0, 20);
	endtask : t_pol
	task automatic t_dly();
		bus(1, rlts_pkg::REG_CTRL, 32'h0303);
		rain <= 1;
		repeat (20) @(posedge clk_i);
		rain <= 0;
		repeat (80) @(posedge clk_i);
		chk(lim, 0);
		rain <= 1;
		repeat (30) @(posedge clk_i);
		chk(lim, 0);
		wl(1, 40);
		bus(1, rlts_pkg::REG_CTRL, 32'h8001);
		bus(1, rlts_pkg::REG_CYCLE, 1);
		wt();
		wt();
		chk(t, 100);
		rain <= 0;
		repeat (1700) @(posedge clk_i);
		chk({lim, last}, 2'b11);
		wl(0, 200);
		wt();
		chk(txv, 0);
	endtask : t_dly
	task automatic t_inh();
		bus(1, rlts_pkg::REG_CYCLE, 0);
		n = cnt;
		rain <= 1;
		repeat (50) @(posedge clk_i);
		rain <= 0;
		repeat (50) @(posedge clk_i);
		chk(cnt, n);
		bus(1, rlts_pkg::REG_CTRL, 32'hF);
		rain <= 1;
		bus(1, rlts_pkg::REG_CYCLE, 1);
		repeat (250) @(posedge clk_i);
		chk(cnt, n);
		rain <= 0;
		wt();
		chk(txv, 0);
	endtask : t_inh
	task automatic t_irq();
		bus(1, rlts_pkg::REG_IRQ_CLR, 7);
		bus(1, rlts_pkg::REG_IRQ_EN, 1);
		wt();
		repeat (3) @(posedge clk_i);
		chk(irq, 1);
		bus(1, rlts_pkg::REG_CYCLE, 0);
		bus(1, rlts_pkg::REG_IRQ_CLR, 1);
		repeat (2) @(posedge clk_i);
		chk(irq, 0);
		bus(1, rlts_pkg::REG_CYCLE, 1);
		bus(1, rlts_pkg::REG_IRQ_EN, 0);
		wt();
		repeat (3) @(posedge clk_i);
		bus(0, rlts_pkg::REG_IRQ_STAT, 0);
		chk({irq, rv[0]}, 2'b01);
	endtask : t_irq
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		t_regs();
		t_pol();
		t_dly();
		t_inh();
		t_irq();
		end_sim();
	end
	initial begin
		#200000;
		errors++;
		end_sim();
	end
endmodule : test_rlts_top
`default_nettype wire
